// File: rtl/mbr_register_bank.sv
// address decoder and read-back register bank of the fieldbus slave
`timescale 1ns/1ps
module mbr_register_bank
  import mbr_pkg::*;
#(
  parameter int IMG_ADDR_W = 8,
  parameter logic [63:0] ORDER_CODE = 64'h0123_4567_89ab_cdef,
  parameter logic [47:0] HW_ADDRESS = 48'h0200_0000_0001,
  parameter logic [15:0] FIRMWARE_LEVEL = 16'h0001,
  parameter logic [15:0] HW_REVISION = 16'h0001,
  parameter logic [15:0] LOADER_VERSION = 16'h0001,
  parameter logic [15:0] LAYOUT_VERSION = 16'h0001
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_req,
  input wire logic i_req_bit,
  input wire logic i_req_write,
  input wire logic [15:0] i_req_addr,
  input wire logic [15:0] i_req_wdata,
  input wire logic i_app_running,
  input wire logic [15:0] i_flash_part_one,
  input wire logic [15:0] i_flash_part_two,
  input wire logic [15:0] i_flash_part_three,
  input wire logic [1:0] i_watchdog_state,
  input wire logic i_in_img_wr,
  input wire logic [15:0] i_in_img_addr,
  input wire logic [15:0] i_in_img_data,
  output logic o_ack,
  output logic [7:0] o_exception,
  output logic [15:0] o_rdata,
  output logic o_out_img_wr,
  output logic [15:0] o_out_img_addr,
  output logic [15:0] o_out_img_data,
  output logic o_wd_cmd_wr,
  output logic [15:0] o_wd_cmd,
  output logic [15:0] o_wd_timeout,
  output logic [15:0] o_wd_setup,
  output logic [15:0] o_tcp_wd
);
  // arbitrary values of the order code and hardware address parameters above

  mbr_state_type state;
  mbr_state_type next_state;
  logic req_bit;
  logic req_write;
  logic [15:0] req_addr;
  logic [15:0] req_wdata;
  logic [15:0] heartbeat;
  logic [15:0] wd_timeout;
  logic [15:0] wd_setup;
  logic [15:0] tcp_wd;
  logic [15:0] in_word;
  logic [15:0] out_word;
  logic [15:0] bit_in_word;
  logic [15:0] bit_out_word;

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // register windows
  wire reg_in_win = !req_bit && (req_addr <= IN_WIN_LAST);
  wire reg_out_win = !req_bit && in_range(req_addr, OUT_WIN_FIRST, OUT_WIN_LAST);
  wire reg_special = !req_bit && (req_addr > OUT_WIN_LAST);
  wire bit_in_win = req_bit && (req_addr < BIT_OUT_FIRST);
  wire bit_out_win = req_bit && (req_addr >= BIT_OUT_FIRST);
  wire wd_locked = (i_watchdog_state == WD_RUNNING) || (i_watchdog_state == WD_EXPIRED);
  wire [15:0] out_offset = req_addr - OUT_WIN_FIRST;
  wire [15:0] bit_offset = req_addr - BIT_OUT_FIRST;
  wire [IMG_ADDR_W-1:0] in_rd_index = req_bit ? req_addr[IMG_ADDR_W+3:4]
                                              : req_addr[IMG_ADDR_W-1:0];
  wire [IMG_ADDR_W-1:0] out_rd_index = req_bit ? bit_offset[IMG_ADDR_W+3:4]
                                               : out_offset[IMG_ADDR_W-1:0];

  // special register read decode and access check
  logic [15:0] special_rdata;
  logic special_ok;
  always_comb
  begin
    special_rdata = 16'h0000;
    special_ok = 1'b1;
    unique case (req_addr)
      WD_COMMAND_ADDR: special_ok = req_write;
      WD_TIMEOUT_ADDR: special_rdata = wd_timeout;
      WD_STATE_ADDR: special_rdata = {14'h0000, i_watchdog_state};
      WD_SETUP_ADDR: special_rdata = wd_setup;
      TCP_WD_ADDR: special_rdata = tcp_wd;
      FLASH_ONE_ADDR: special_rdata = i_flash_part_one;
      FLASH_TWO_ADDR: special_rdata = i_flash_part_two;
      FLASH_THREE_ADDR: special_rdata = i_flash_part_three;
      RUN_STOP_ADDR: special_rdata = i_app_running ? RUN_STOP_RUNNING : RUN_STOP_HALTED;
      ORDER_CODE_ADDR: special_rdata = ORDER_CODE[63:48];
      ORDER_CODE_ADDR + 16'h0001: special_rdata = ORDER_CODE[47:32];
      ORDER_CODE_ADDR + 16'h0002: special_rdata = ORDER_CODE[31:16];
      ORDER_CODE_ADDR + 16'h0003: special_rdata = ORDER_CODE[15:0];
      FIRMWARE_ADDR: special_rdata = FIRMWARE_LEVEL;
      HW_REV_ADDR: special_rdata = HW_REVISION;
      LOADER_ADDR: special_rdata = LOADER_VERSION;
      LAYOUT_VER_ADDR: special_rdata = LAYOUT_VERSION;
      HW_ADDR_ADDR: special_rdata = HW_ADDRESS[47:32];
      HW_ADDR_ADDR + 16'h0001: special_rdata = HW_ADDRESS[31:16];
      HW_ADDR_ADDR + 16'h0002: special_rdata = HW_ADDRESS[15:0];
      IN_TOTAL_ADDR: special_rdata = IN_TOTAL_VAL;
      IN_ANALOG_ADDR: special_rdata = IN_ANALOG_VAL;
      IN_DIGITAL_ADDR: special_rdata = IN_DIGITAL_VAL;
      OUT_TOTAL_ADDR: special_rdata = OUT_TOTAL_VAL;
      OUT_ANALOG_ADDR: special_rdata = OUT_ANALOG_VAL;
      OUT_DIGITAL_ADDR: special_rdata = OUT_DIGITAL_VAL;
      PATTERN_ONE_ADDR: special_rdata = PATTERN_ONE_VAL;
      PATTERN_TWO_ADDR: special_rdata = PATTERN_TWO_VAL;
      PATTERN_THREE_ADDR: special_rdata = PATTERN_THREE_VAL;
      HEARTBEAT_ADDR: special_rdata = heartbeat;
      default: special_ok = 1'b0;
    endcase
  end

  wire special_writable = (req_addr == WD_COMMAND_ADDR) || (req_addr == WD_TIMEOUT_ADDR) ||
                          (req_addr == WD_SETUP_ADDR) || (req_addr == TCP_WD_ADDR);
  wire timeout_refused = req_write && (req_addr == WD_TIMEOUT_ADDR) && wd_locked;

  // exception code for the held request
  logic [7:0] exc_code;
  always_comb
  begin
    exc_code = EXC_NONE;
    if (reg_in_win && req_write)
    begin
      exc_code = EXC_ILLEGAL_FUNCTION;
    end
    else if (bit_in_win && req_write)
    begin
      exc_code = EXC_ILLEGAL_FUNCTION;
    end
    else if (reg_special && !special_ok)
    begin
      exc_code = EXC_ILLEGAL_ADDRESS;
    end
    else if (reg_special && req_write && !special_writable)
    begin
      exc_code = EXC_ILLEGAL_FUNCTION;
    end
    else if (timeout_refused)
    begin
      exc_code = EXC_ILLEGAL_FUNCTION;
    end
  end

  wire accept_write = req_write && (exc_code == EXC_NONE);
  wire do_out_write = accept_write && !req_bit && reg_out_win;
  wire do_bit_write = accept_write && bit_out_win;
  wire [3:0] bit_sel = req_addr[3:0];

  // read-modify-write merges a single coil into its image word
  wire [15:0] bit_mask = 16'h0001 << bit_sel;
  wire [15:0] merged_word = req_wdata[0] ? (bit_out_word | bit_mask)
                                          : (bit_out_word & ~bit_mask);

  // the output image is kept locally as a shadow so reads return what was written
  wire out_mem_wr = (state == MBR_ANSWER) && (do_out_write || do_bit_write);
  wire [15:0] out_mem_data = do_bit_write ? merged_word : req_wdata;

  mbr_image_mem #(
    .ADDR_W(IMG_ADDR_W),
    .DATA_W(16)
  ) u_in_image (
    .i_ref_clk(i_ref_clk),
    .i_wr_en(i_in_img_wr),
    .i_wr_addr(i_in_img_addr[IMG_ADDR_W-1:0]),
    .i_wr_data(i_in_img_data),
    .i_rd_addr(in_rd_index),
    .o_rd_data(in_word)
  );

  mbr_image_mem #(
    .ADDR_W(IMG_ADDR_W),
    .DATA_W(16)
  ) u_out_image (
    .i_ref_clk(i_ref_clk),
    .i_wr_en(out_mem_wr),
    .i_wr_addr(out_rd_index),
    .i_wr_data(out_mem_data),
    .i_rd_addr(out_rd_index),
    .o_rd_data(out_word)
  );

  assign bit_in_word = in_word;
  assign bit_out_word = out_word;

  // read data selection in the answer cycle
  logic [15:0] next_rdata;
  always_comb
  begin
    next_rdata = 16'h0000;
    if (exc_code != EXC_NONE || req_write)
    begin
      next_rdata = 16'h0000;
    end
    else if (reg_in_win)
    begin
      next_rdata = in_word;
    end
    else if (reg_out_win)
    begin
      next_rdata = out_word;
    end
    else if (bit_in_win)
    begin
      next_rdata = {15'h0000, bit_in_word[bit_sel]};
    end
    else if (bit_out_win)
    begin
      next_rdata = {15'h0000, bit_out_word[bit_sel]};
    end
    else
    begin
      next_rdata = special_rdata;
    end
  end

  // idle takes a request, look waits for the image read, answer replies
  always_comb
  begin
    unique case (state)
      MBR_IDLE: next_state = i_req ? MBR_LOOK : MBR_IDLE;
      MBR_LOOK: next_state = MBR_ANSWER;
      MBR_ANSWER: next_state = MBR_IDLE;
      default: next_state = MBR_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state <= MBR_IDLE;
      req_bit <= 1'b0;
      req_write <= 1'b0;
      req_addr <= 16'h0000;
      req_wdata <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      if (state == MBR_IDLE && i_req)
      begin
        req_bit <= i_req_bit;
        req_write <= i_req_write;
        req_addr <= i_req_addr;
        req_wdata <= i_req_wdata;
      end
    end
  end

  wire answering = (state == MBR_ANSWER);
  wire special_write = answering && accept_write && reg_special;

  // writable special registers and the free-running heartbeat counter
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wd_timeout <= TIMEOUT_RESET;
      wd_setup <= SETUP_RESET;
      tcp_wd <= TCP_WD_RESET;
      heartbeat <= 16'h0000;
    end
    else
    begin
      // free-running so a master can see the device is alive
      heartbeat <= heartbeat + 16'h0001;
      if (special_write && req_addr == WD_TIMEOUT_ADDR)
      begin
        wd_timeout <= req_wdata;
      end
      if (special_write && req_addr == WD_SETUP_ADDR)
      begin
        wd_setup <= req_wdata;
      end
      if (special_write && req_addr == TCP_WD_ADDR)
      begin
        tcp_wd <= req_wdata;
      end
    end
  end

  // answer and strobe outputs
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_ack <= 1'b0;
      o_exception <= EXC_NONE;
      o_rdata <= 16'h0000;
      o_out_img_wr <= 1'b0;
      o_out_img_addr <= 16'h0000;
      o_out_img_data <= 16'h0000;
      o_wd_cmd_wr <= 1'b0;
      o_wd_cmd <= 16'h0000;
    end
    else
    begin
      o_ack <= answering;
      o_exception <= answering ? exc_code : EXC_NONE;
      o_rdata <= answering ? next_rdata : 16'h0000;
      o_out_img_wr <= out_mem_wr;
      o_wd_cmd_wr <= special_write && (req_addr == WD_COMMAND_ADDR);
      if (out_mem_wr)
      begin
        o_out_img_addr <= req_bit ? {4'h0, bit_offset[15:4]} : out_offset;
        o_out_img_data <= out_mem_data;
      end
      if (special_write && req_addr == WD_COMMAND_ADDR)
      begin
        o_wd_cmd <= req_wdata;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_wd_timeout <= TIMEOUT_RESET;
      o_wd_setup <= SETUP_RESET;
      o_tcp_wd <= TCP_WD_RESET;
    end
    else
    begin
      o_wd_timeout <= wd_timeout;
      o_wd_setup <= wd_setup;
      o_tcp_wd <= tcp_wd;
    end
  end
endmodule

// File: rtl/mbr_pkg.sv
// package with the register map, window limits and reset values of the register bank
package mbr_pkg;
  localparam logic [15:0] IN_WIN_LAST = 16'h7cff;
  localparam logic [15:0] OUT_WIN_FIRST = 16'h7d00;
  localparam logic [15:0] OUT_WIN_LAST = 16'hf9ff;
  localparam logic [15:0] BIT_OUT_FIRST = 16'h8000;
  localparam logic [15:0] WD_COMMAND_ADDR = 16'hfa00;
  localparam logic [15:0] WD_TIMEOUT_ADDR = 16'hfa01;
  localparam logic [15:0] WD_STATE_ADDR = 16'hfa02;
  localparam logic [15:0] WD_SETUP_ADDR = 16'hfa03;
  localparam logic [15:0] TCP_WD_ADDR = 16'hfa04;
  localparam logic [15:0] FLASH_ONE_ADDR = 16'hfa0a;
  localparam logic [15:0] FLASH_TWO_ADDR = 16'hfa0b;
  localparam logic [15:0] FLASH_THREE_ADDR = 16'hfa0c;
  localparam logic [15:0] RUN_STOP_ADDR = 16'hfa0d;
  localparam logic [15:0] ORDER_CODE_ADDR = 16'hfa10;
  localparam logic [15:0] FIRMWARE_ADDR = 16'hfa14;
  localparam logic [15:0] HW_REV_ADDR = 16'hfa15;
  localparam logic [15:0] LOADER_ADDR = 16'hfa16;
  localparam logic [15:0] LAYOUT_VER_ADDR = 16'hfa17;
  localparam logic [15:0] HW_ADDR_ADDR = 16'hfa20;
  localparam logic [15:0] IN_TOTAL_ADDR = 16'hfa40;
  localparam logic [15:0] IN_ANALOG_ADDR = 16'hfa41;
  localparam logic [15:0] IN_DIGITAL_ADDR = 16'hfa42;
  localparam logic [15:0] OUT_TOTAL_ADDR = 16'hfa43;
  localparam logic [15:0] OUT_ANALOG_ADDR = 16'hfa44;
  localparam logic [15:0] OUT_DIGITAL_ADDR = 16'hfa45;
  localparam logic [15:0] PATTERN_ONE_ADDR = 16'hfaa0;
  localparam logic [15:0] PATTERN_TWO_ADDR = 16'hfaa1;
  localparam logic [15:0] PATTERN_THREE_ADDR = 16'hfaa2;
  localparam logic [15:0] HEARTBEAT_ADDR = 16'hfafa;
  localparam logic [15:0] IN_TOTAL_VAL = 16'h7d00;
  localparam logic [15:0] IN_ANALOG_VAL = 16'h7d00;
  localparam logic [15:0] IN_DIGITAL_VAL = 16'h8000;
  localparam logic [15:0] OUT_TOTAL_VAL = 16'h7d00;
  localparam logic [15:0] OUT_ANALOG_VAL = 16'h7d00;
  localparam logic [15:0] OUT_DIGITAL_VAL = 16'h8000;
  localparam logic [15:0] PATTERN_ONE_VAL = 16'h1234;
  localparam logic [15:0] PATTERN_TWO_VAL = 16'haaaa;
  localparam logic [15:0] PATTERN_THREE_VAL = 16'h5555;
  localparam logic [15:0] RUN_STOP_HALTED = 16'h0001;
  localparam logic [15:0] RUN_STOP_RUNNING = 16'h0002;
  localparam logic [15:0] TIMEOUT_RESET = 16'h0000;
  localparam logic [15:0] SETUP_RESET = 16'h0000;
  localparam logic [15:0] TCP_WD_RESET = 16'h0000;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_ILLEGAL_FUNCTION = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDRESS = 8'h02;
  localparam logic [1:0] WD_UNCONFIGURED = 2'h0;
  localparam logic [1:0] WD_STOPPED = 2'h1;
  localparam logic [1:0] WD_RUNNING = 2'h2;
  localparam logic [1:0] WD_EXPIRED = 2'h3;
  typedef enum logic [1:0] {
    MBR_IDLE = 2'b00,
    MBR_LOOK = 2'b01,
    MBR_ANSWER = 2'b11
  } mbr_state_type;
endpackage

// File: rtl/mbr_image_mem.sv
// process-image memory with registered read data
`timescale 1ns/1ps
module mbr_image_mem
  import mbr_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 16
)
(
  input wire logic i_ref_clk,
  input wire logic i_wr_en,
  input wire logic [ADDR_W-1:0] i_wr_addr,
  input wire logic [DATA_W-1:0] i_wr_data,
  input wire logic [ADDR_W-1:0] i_rd_addr,
  output logic [DATA_W-1:0] o_rd_data
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // no reset: contents are undefined until the image is first written
  always_ff @(posedge i_ref_clk)
  begin
    if (i_wr_en)
    begin
      mem[i_wr_addr] <= i_wr_data;
    end
    o_rd_data <= mem[i_rd_addr];
  end
endmodule

// File: sim/mbr_register_bank_props.sv
// concurrent checks on the ports of the fieldbus register bank
`timescale 1ns/1ps
module mbr_register_bank_props
  import mbr_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_req,
  input wire logic i_req_bit,
  input wire logic i_req_write,
  input wire logic [15:0] i_req_addr,
  input wire logic [15:0] i_req_wdata,
  input wire logic i_app_running,
  input wire logic [15:0] i_flash_part_two,
  input wire logic [1:0] i_watchdog_state,
  input wire logic o_ack,
  input wire logic [7:0] o_exception,
  input wire logic [15:0] o_rdata,
  input wire logic o_out_img_wr,
  input wire logic [15:0] o_out_img_addr,
  input wire logic [15:0] o_out_img_data
);
  logic [1:0] busy;
  logic take;
  logic rd_reg;
  logic wr_reg;
  logic wr_bit;
  logic [15:0] size_exp;
  // a request is only taken outside the two busy cycles after the last one
  assign take = i_req && (busy == 2'h0);
  assign rd_reg = take && !i_req_bit && !i_req_write;
  assign wr_reg = take && !i_req_bit && i_req_write;
  assign wr_bit = take && i_req_bit && i_req_write;
  assign size_exp = (i_req_addr[1:0] == 2'h2 || i_req_addr[1:0] == 2'h1 && i_req_addr[2]) ?
                    16'h8000 : 16'h7d00;
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      busy <= 2'h0;
    else if (take)
      busy <= 2'h2;
    else if (busy != 2'h0)
      busy <= busy - 2'h1;
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  ack_latency_a: assert property (take |-> ##3 o_ack) else $error("late answer");
  ack_cause_a: assert property (o_ack |-> $past(take, 3)) else $error("answer without request");
  in_win_wr_a: assert property (wr_reg && i_req_addr <= 16'h7cff |-> ##3
    o_exception == 8'h01 && !o_out_img_wr) else $error("input window write taken");
  out_win_wr_a: assert property (wr_reg && i_req_addr inside {[16'h7d00:16'hf9ff]} |-> ##3
    o_out_img_wr && o_exception == 8'h00 && o_out_img_data == $past(i_req_wdata, 3)
    && o_out_img_addr == $past(i_req_addr, 3) - 16'h7d00) else $error("output write lost");
  in_bit_wr_a: assert property (wr_bit && !i_req_addr[15] |-> ##3 o_exception == 8'h01)
    else $error("input bit write taken");
  out_bit_wr_a: assert property (wr_bit && i_req_addr[15] |-> ##3 o_exception == 8'h00)
    else $error("output bit write refused");
  run_stop_a: assert property (rd_reg && i_req_addr == 16'hfa0d |-> ##3
    o_rdata == ($past(i_app_running, 1) ? 16'h0002 : 16'h0001)) else $error("bad run state");
  flash_two_a: assert property (rd_reg && i_req_addr == 16'hfa0b |-> ##3
    o_rdata == $past(i_flash_part_two, 1)) else $error("bad flash part");
  size_regs_a: assert property (rd_reg && i_req_addr inside {[16'hfa40:16'hfa45]} |-> ##3
    o_rdata == $past(size_exp, 3)) else $error("bad size register");
  timeout_lock_a: assert property (wr_reg && i_req_addr == 16'hfa01 && i_watchdog_state[1]
    |-> ##3 o_exception == 8'h01) else $error("locked timeout written");
  cover property (wr_reg ##3 o_out_img_wr);
  cover property (wr_bit ##3 o_ack);
  cover property (rd_reg ##3 o_exception == 8'h02);
endmodule
bind mbr_register_bank mbr_register_bank_props u_mbr_register_bank_props (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_req(i_req), .i_req_bit(i_req_bit),
  .i_req_write(i_req_write), .i_req_addr(i_req_addr), .i_req_wdata(i_req_wdata),
  .i_app_running(i_app_running), .i_flash_part_two(i_flash_part_two),
  .i_watchdog_state(i_watchdog_state), .o_ack(o_ack), .o_exception(o_exception),
  .o_rdata(o_rdata), .o_out_img_wr(o_out_img_wr), .o_out_img_addr(o_out_img_addr),
  .o_out_img_data(o_out_img_data));

// File: sim/mbr_modbus_master.sv
// behavioural fieldbus master that issues register and bit requests
`timescale 1ns/1ps
module mbr_modbus_master
(
  input wire logic i_ref_clk,
  input wire logic i_ack,
  input wire logic [7:0] i_exception,
  input wire logic [15:0] i_rdata,
  output logic o_req,
  output logic o_req_bit,
  output logic o_req_write,
  output logic [15:0] o_req_addr,
  output logic [15:0] o_req_wdata
);
  initial
  begin
    o_req = 1'b0;
    o_req_bit = 1'b0;
    o_req_write = 1'b0;
    o_req_addr = 16'h0000;
    o_req_wdata = 16'h0000;
  end
  task automatic access(input logic b, w, input logic [15:0] a, d,
                        output logic [7:0] exc, output logic [15:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    exc = 8'h00;
    rd = 16'h0000;
    @(negedge i_ref_clk);
    o_req = 1'b1;
    o_req_bit = b;
    o_req_write = w;
    o_req_addr = a;
    o_req_wdata = d;
    @(negedge i_ref_clk);
    // one-cycle strobe: held past the answer cycle into idle it would be taken a second time;
    // the qualifiers stay put until the answer has been taken
    o_req = 1'b0;
    for (n = 0; n < 8 && !ok; n++)
    begin
      if (i_ack === 1'b1)
      begin
        ok = 1'b1;
        exc = i_exception;
        rd = i_rdata;
      end
      else
        @(negedge i_ref_clk);
    end
  endtask
endmodule

// File: sim/tb_mbr_register_bank.sv
// self-checking bench for the fieldbus register bank
`timescale 1ns/1ps
module tb_mbr_register_bank;
  import mbr_pkg::*;
  logic clk, rst_n, run, img_wr, req, rbit, rwr, ack, out_wr, cmd_wr, ok;
  logic [1:0] wd_st;
  logic [7:0] exc, g_exc;
  logic [15:0] fl1, fl2, fl3, img_addr, img_data, raddr, rwdata, rdata, out_addr, out_data;
  logic [15:0] wd_cmd, wd_to, wd_setup, tcp_wd, g_rd, hb;
  logic [15:0] tbl_a [9] = '{16'hfa40, 16'hfa41, 16'hfa42, 16'hfa43, 16'hfa44, 16'hfa45,
                             16'hfaa0, 16'hfaa1, 16'hfaa2};
  logic [15:0] tbl_v [9] = '{16'h7d00, 16'h7d00, 16'h8000, 16'h7d00, 16'h7d00, 16'h8000,
                             16'h1234, 16'haaaa, 16'h5555};
  int miscompares = 0;
  int checks_done = 0;
  int i;
  mbr_register_bank #(.LAYOUT_VERSION(16'h0042)) u_mbr_register_bank (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_req_bit(rbit), .i_req_write(rwr),
    .i_req_addr(raddr), .i_req_wdata(rwdata), .i_app_running(run), .i_flash_part_one(fl1),
    .i_flash_part_two(fl2), .i_flash_part_three(fl3), .i_watchdog_state(wd_st),
    .i_in_img_wr(img_wr), .i_in_img_addr(img_addr), .i_in_img_data(img_data), .o_ack(ack),
    .o_exception(exc), .o_rdata(rdata), .o_out_img_wr(out_wr), .o_out_img_addr(out_addr),
    .o_out_img_data(out_data), .o_wd_cmd_wr(cmd_wr), .o_wd_cmd(wd_cmd), .o_wd_timeout(wd_to),
    .o_wd_setup(wd_setup), .o_tcp_wd(tcp_wd));
  mbr_modbus_master u_mbr_modbus_master (
    .i_ref_clk(clk), .i_ack(ack), .i_exception(exc), .i_rdata(rdata), .o_req(req),
    .o_req_bit(rbit), .o_req_write(rwr), .o_req_addr(raddr), .o_req_wdata(rwdata));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task acc(input logic b, w, input logic [15:0] a, d, input logic [7:0] e);
    u_mbr_modbus_master.access(b, w, a, d, g_exc, g_rd, ok);
    if (!ok)
    begin
      miscompares++;
      $display("MISMATCH answer expected 1 seen 0");
      end_sim();
    end
    else
      chk("exception", {8'h00, e}, {8'h00, g_exc});
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e, input logic [15:0] v);
    acc(1'b0, 1'b0, a, 16'h0000, e);
    chk("read data", v, g_rd);
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim();
  end
  initial
  begin
    {rst_n, run, img_wr} = 3'h0;
    wd_st = WD_STOPPED;
    {fl1, fl2, fl3} = {16'h0a01, 16'h0b02, 16'h0c03};
    {img_addr, img_data} = 32'h0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk("ack", 16'h0000, {15'h0, ack});
    chk("timeout", TIMEOUT_RESET, wd_to);
    for (i = 0; i < 9; i++) rd(tbl_a[i], 8'h00, tbl_v[i]);
    rd(16'hfa0d, 8'h00, 16'h0001);
    run = 1'b1;
    rd(16'hfa0d, 8'h00, 16'h0002);
    rd(16'hfa0a, 8'h00, 16'h0a01);
    rd(16'hfa0b, 8'h00, 16'h0b02);
    rd(16'hfa0c, 8'h00, 16'h0c03);
    rd(16'hfa17, 8'h00, 16'h0042);
    {img_wr, img_addr, img_data} = {1'b1, 16'h0003, 16'h8001};
    @(negedge clk);
    img_wr = 1'b0;
    rd(16'h0003, 8'h00, 16'h8001);
    acc(1'b0, 1'b1, 16'h7cff, 16'hffff, 8'h01);
    chk("refused strobe", 16'h0000, {15'h0, out_wr});
    acc(1'b0, 1'b1, 16'h7d00, 16'h0002, 8'h00);
    chk("image strobe", 16'h0001, {15'h0, out_wr});
    chk("image offset", 16'h0000, out_addr);
    chk("image data", 16'h0002, out_data);
    acc(1'b0, 1'b1, 16'hf9ff, 16'hbeef, 8'h00);
    rd(16'hf9ff, 8'h00, 16'hbeef);
    acc(1'b0, 1'b1, 16'hfa40, 16'h0001, 8'h01);
    rd(16'hfa50, 8'h02, 16'h0000);
    rd(16'hfa02, 8'h00, 16'h0001);
    acc(1'b1, 1'b0, 16'h0030, 16'h0000, 8'h00);
    chk("bit", 16'h0001, g_rd);
    acc(1'b1, 1'b0, 16'h0031, 16'h0000, 8'h00);
    chk("bit", 16'h0000, g_rd);
    acc(1'b1, 1'b1, 16'h7fff, 16'h0001, 8'h01);
    acc(1'b1, 1'b1, 16'h8000, 16'h0001, 8'h00);
    rd(16'h7d00, 8'h00, 16'h0003);
    acc(1'b0, 1'b1, 16'hfa01, 16'h1234, 8'h00);
    @(negedge clk);
    chk("timeout", 16'h1234, wd_to);
    wd_st = WD_RUNNING;
    acc(1'b0, 1'b1, 16'hfa01, 16'h5678, 8'h01);
    wd_st = WD_EXPIRED;
    acc(1'b0, 1'b1, 16'hfa01, 16'h5678, 8'h01);
    @(negedge clk);
    chk("timeout", 16'h1234, wd_to);
    acc(1'b0, 1'b1, 16'hfa00, 16'h5555, 8'h00);
    chk("command strobe", 16'h0001, {15'h0, cmd_wr});
    chk("command", 16'h5555, wd_cmd);
    acc(1'b0, 1'b1, 16'hfa03, 16'h00a5, 8'h00);
    acc(1'b0, 1'b1, 16'hfa04, 16'h0033, 8'h00);
    @(negedge clk);
    chk("setup", 16'h00a5, wd_setup);
    chk("tcp watchdog", 16'h0033, tcp_wd);
    rd(16'hfa03, 8'h00, 16'h00a5);
    rd(16'hfa04, 8'h00, 16'h0033);
    // the first sample anchors the count and must be nonzero; the second must be four clocks on
    acc(1'b0, 1'b0, 16'hfafa, 16'h0000, 8'h00);
    hb = g_rd;
    chk("heartbeat live", 16'h0001, {15'h0, hb != 16'h0000});
    acc(1'b0, 1'b0, 16'hfafa, 16'h0000, 8'h00);
    chk("heartbeat", hb + 16'h0004, g_rd);
    end_sim();
  end
endmodule
